// >>> flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_CONFIG = 8'h14;
    // status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_AUTOSEL = 3;
    localparam int ST_BYPASS = 4;
    localparam int ST_RDYPIN = 5;
    localparam int ST_ABORTED = 6;
    // config field positions
    localparam int CF_BYTE = 0;
    localparam int CF_HWRST = 1;
    localparam int CF_VID = 2;
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    // operation codes written to the control register
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_RESET = 3'h1;
    localparam logic [2:0] OP_PROGRAM = 3'h2;
    localparam logic [2:0] OP_AUTOSEL = 3'h3;
    localparam logic [2:0] OP_BYPASS = 3'h4;
    localparam logic [2:0] OP_BYPPROG = 3'h5;
    localparam logic [2:0] OP_BYPEXIT = 3'h6;
    // command data values
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [15:0] CMD_BYPASS = 16'h0020;
    localparam logic [15:0] CMD_BYPEXIT1 = 16'h0090;
    localparam logic [15:0] CMD_BYPEXIT2 = 16'h0000;
    localparam logic [15:0] UNLOCK_DATA1_DEF = 16'h00aa;
    localparam logic [15:0] UNLOCK_DATA2_DEF = 16'h0055;
    localparam logic [19:0] UNLOCK_ADDR1_DEF = 20'h00555;
    localparam logic [19:0] UNLOCK_ADDR2_DEF = 20'h002aa;
    // bus timing, in ns and in clock cycles rounded up
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_SETUP_NS = 25;
    localparam int T_PULSE_NS = 60;
    localparam int T_HOLD_NS = 25;
    localparam int T_BUSY_NS = 100;
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] BUSY_CYC = 8'((T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // one bus cycle of a command sequence
    typedef struct packed {
        logic rd;
        logic [19:0] addr;
        logic [15:0] data;
    } bus_cycle_t;
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_BUSYW} seq_state_t;
endpackage : flash_host_pkg
`default_nettype wire

// >>> flash_host.sv
`default_nettype none
// Behaviour
// R1 - no command accepted during power-up strobes
// R2 - device starts in array read
// R3 - high reset voltage unprotects sectors temporarily
// R4 - bad or misordered write returns array read
// R5 - address on later fall, data earlier rise
// R6 - embedded operation ends in array read
// R7 - erase-suspend reads give status in suspended sectors
// R8 - reset command anywhere restores array read; the host refuses it in bypass mode
// R9 - reset aborts sequences, ignored once running
// R10 - autoselect held until reset command
// R11 - reset after fault bit restores read
// R12 - unlock plus autoselect enters autoselect mode
// R13 - autoselect addresses give identification codes
// R14 - sector plus 02h reads protection state
// R15 - program is four writes, last starts algorithm
// R16 - byte pin picks word or byte programming
// R17 - commands ignored while program runs
// R18 - hardware reset kills program, reissue afterwards
// R19 - programming cannot turn zero into one
// R20 - unlock plus 20h enters bypass mode
// R21 - bypass program is A0h then address/data
// R22 - bypass accepts program and 90h,00h exit only
// R23 - write needs chip select, write low, output high
// R24 - unlock values are decoder parameters, matched exactly
module flash_host import flash_host_pkg::*; #(
    parameter logic [19:0] UNLOCK_ADDR1 = UNLOCK_ADDR1_DEF,
    parameter logic [19:0] UNLOCK_ADDR2 = UNLOCK_ADDR2_DEF,
    parameter logic [15:0] UNLOCK_DATA1 = UNLOCK_DATA1_DEF,
    parameter logic [15:0] UNLOCK_DATA2 = UNLOCK_DATA2_DEF
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic [19:0] flashAddr,
    output logic [15:0] flashDqOut,
    output logic flashDqOeN,
    input wire logic [15:0] flashDqIn,
    output logic flashByteN,
    output logic flashResetN,
    output logic flashVidEn,
    input wire logic readyBusy
);
    seq_state_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [1:0] step_r, step_nxt;
    logic [2:0] op_r, op_nxt;
    logic [2:0] ctrlOp_r;
    logic [19:0] addr_r;
    logic [15:0] wdata_r, rdata_r;
    logic [2:0] config_r;
    logic done_r, refused_r, aborted_r, autosel_r, bypass_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic ceN_r, weN_r, oeN_r, dqOeN_r;
    logic [19:0] pinAddr_r;
    logic [15:0] pinData_r;
    bus_cycle_t cur, curNxt;

    // bus cycle of a given step of a given operation
    function automatic bus_cycle_t stepOf(input logic [2:0] op, input logic [1:0] idx,
                                          input logic [19:0] a, input logic [15:0] d);
        bus_cycle_t c;
        c = '{rd: 1'b0, addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
        unique case (op)
            OP_READ: c = '{rd: 1'b1, addr: a, data: 16'h0000};
            OP_RESET: c.data = CMD_RESET; // see R8
            OP_BYPPROG: c = (idx == 2'd0) ? '{rd: 1'b0, addr: UNLOCK_ADDR1, data: CMD_PROGRAM}
                                          : '{rd: 1'b0, addr: a, data: d}; // see R21
            OP_BYPEXIT: c.data = (idx == 2'd0) ? CMD_BYPEXIT1 : CMD_BYPEXIT2; // see R22
            default: begin
                // unlock pair then command, program adds address/data
                if (idx == 2'd1) begin
                    c = '{rd: 1'b0, addr: UNLOCK_ADDR2, data: UNLOCK_DATA2}; // see R24
                end else if (idx == 2'd2) begin
                    c.data = (op == OP_PROGRAM) ? CMD_PROGRAM : (op == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_BYPASS;
                end else if (idx == 2'd3) begin
                    c = '{rd: 1'b0, addr: a, data: d}; // see R15
                end
            end
        endcase
        return c;
    endfunction

    // index of the final step of each operation
    function automatic logic [1:0] lastOf(input logic [2:0] op);
        logic [1:0] n;
        n = 2'd0;
        unique case (op)
            OP_PROGRAM: n = 2'd3;
            OP_AUTOSEL, OP_BYPASS: n = 2'd2;
            OP_BYPPROG, OP_BYPEXIT: n = 2'd1;
            default: n = 2'd0;
        endcase
        return n;
    endfunction

    // apb decode
    wire logic apbAccess = psel & penable & pready_r;
    wire logic apbWr = apbAccess & pwrite;
    wire logic addrHit = (paddr == REG_CTRL) | (paddr == REG_ADDR) | (paddr == REG_WDATA) |
                         (paddr == REG_STATUS) | (paddr == REG_RDATA) | (paddr == REG_CONFIG);
    wire logic hwReset = config_r[CF_HWRST];
    wire logic startReq = apbWr & (paddr == REG_CTRL);
    wire logic [2:0] reqOp = pwdata[2:0];
    wire logic isBypassOp = (reqOp == OP_BYPPROG) | (reqOp == OP_BYPEXIT);
    // mode guard: bypass allows only its own ops and reads, autoselect only reset and reads
    wire logic opLegal = (reqOp == OP_READ) |
                         (bypass_r ? isBypassOp : (!isBypassOp && reqOp != 3'h7 &&
                                                   (!autosel_r || reqOp == OP_RESET))); // see R10 see R22
    wire logic accept = startReq & (state_r == S_IDLE) & opLegal & !hwReset;
    wire logic refuse = startReq & !accept;
    wire logic isLast = (step_r == lastOf(op_r));
    wire logic needsWait = (op_r == OP_PROGRAM) | (op_r == OP_BYPPROG);
    wire logic finish = ((state_r == S_HOLD) && (cnt_r == 8'd0) && isLast && !needsWait) ||
                        ((state_r == S_BUSYW) && (cnt_r == 8'd0) && readyBusy);
    wire logic [31:0] statusWord = {25'h0000000, aborted_r, readyBusy, bypass_r, autosel_r,
                                    refused_r, done_r, state_r != S_IDLE};
    assign cur = stepOf(op_r, step_r, addr_r, wdata_r);
    assign curNxt = stepOf(op_nxt, step_nxt, addr_r, wdata_r);

    // bus cycle sequencer; hardware reset abandons whatever runs
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r == 8'd0) ? 8'd0 : cnt_r - 8'd1;
        step_nxt = step_r;
        op_nxt = op_r;
        if (hwReset) begin
            state_nxt = S_IDLE; // see R18
        end else begin
            unique case (state_r)
                S_IDLE: if (accept) begin
                    state_nxt = S_SETUP;
                    op_nxt = reqOp;
                    step_nxt = 2'd0;
                    cnt_nxt = SETUP_CYC - 8'd1;
                end
                S_SETUP: if (cnt_r == 8'd0) begin
                    state_nxt = S_PULSE;
                    cnt_nxt = PULSE_CYC - 8'd1;
                end
                S_PULSE: if (cnt_r == 8'd0) begin
                    state_nxt = S_HOLD;
                    cnt_nxt = HOLD_CYC - 8'd1;
                end
                S_HOLD: if (cnt_r == 8'd0) begin
                    if (!isLast) begin
                        state_nxt = S_SETUP;
                        step_nxt = step_r + 2'd1;
                        cnt_nxt = SETUP_CYC - 8'd1;
                    end else if (needsWait) begin
                        state_nxt = S_BUSYW; // see R17
                        cnt_nxt = BUSY_CYC - 8'd1;
                    end else begin
                        state_nxt = S_IDLE;
                    end
                end
                S_BUSYW: if (cnt_r == 8'd0 && readyBusy) begin
                    state_nxt = S_IDLE;
                end
            endcase
        end
    end

    // sequencer state
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= S_IDLE;
            cnt_r <= 8'd0;
            step_r <= 2'd0;
            op_r <= OP_READ;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            step_r <= step_nxt;
            op_r <= op_nxt;
        end
    end

    // flash pins from the next state; write pulse only with oe high
    always_ff @(posedge clk) begin
        if (srst) begin
            ceN_r <= 1'b1;
            weN_r <= 1'b1; // see R1
            oeN_r <= 1'b1;
            dqOeN_r <= 1'b1;
            pinAddr_r <= 20'h00000;
            pinData_r <= 16'h0000;
        end else begin
            ceN_r <= !(state_nxt == S_SETUP || state_nxt == S_PULSE);
            weN_r <= !(state_nxt == S_PULSE && !curNxt.rd); // see R23 see R5
            oeN_r <= !(state_nxt == S_PULSE && curNxt.rd);
            dqOeN_r <= !(state_nxt != S_IDLE && state_nxt != S_BUSYW && !curNxt.rd);
            pinAddr_r <= curNxt.addr;
            pinData_r <= curNxt.data;
        end
    end

    // read capture at the end of the output enable pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 16'h0000;
        end else if (state_r == S_PULSE && cnt_r == 8'd0 && cur.rd) begin
            rdata_r <= config_r[CF_BYTE] ? {8'h00, flashDqIn[7:0]} : flashDqIn;
        end
    end

    // mode tracking mirrors the device command state
    always_ff @(posedge clk) begin
        if (srst || hwReset) begin
            autosel_r <= 1'b0;
            bypass_r <= 1'b0;
        end else if (finish) begin
            if (op_r == OP_RESET) begin
                autosel_r <= 1'b0; // see R10
            end else if (op_r == OP_AUTOSEL) begin
                autosel_r <= 1'b1;
            end else if (op_r == OP_BYPASS) begin
                bypass_r <= 1'b1;
            end else if (op_r == OP_BYPEXIT) begin
                bypass_r <= 1'b0; // see R22
            end
        end
    end

    // sticky flags, write one to clear, a set in the same cycle wins
    wire logic clrWr = apbWr & (paddr == REG_STATUS);
    wire logic abortEv = hwReset & (state_r != S_IDLE);
    always_ff @(posedge clk) begin
        if (srst) begin
            done_r <= 1'b0;
            refused_r <= 1'b0;
            aborted_r <= 1'b0;
        end else begin
            done_r <= finish | (done_r & !(clrWr & pwdata[ST_DONE]));
            refused_r <= refuse | (refused_r & !(clrWr & pwdata[ST_REFUSED]));
            aborted_r <= abortEv | (aborted_r & !(clrWr & pwdata[ST_ABORTED])); // see R18
        end
    end

    // software registers and apb answer one wait cycle after setup
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrlOp_r <= OP_READ;
            addr_r <= 20'h00000;
            wdata_r <= 16'h0000;
            config_r <= CONFIG_RESET;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= psel & penable & !pready_r;
            pslverr_r <= psel & penable & !pready_r & !addrHit;
            if (psel && penable && !pready_r) begin
                unique case (paddr)
                    REG_CTRL: prdata_r <= {29'h00000000, ctrlOp_r};
                    REG_ADDR: prdata_r <= {12'h000, addr_r};
                    REG_WDATA: prdata_r <= {16'h0000, wdata_r};
                    REG_STATUS: prdata_r <= statusWord;
                    REG_RDATA: prdata_r <= {16'h0000, rdata_r};
                    REG_CONFIG: prdata_r <= {29'h00000000, config_r};
                    default: prdata_r <= 32'h00000000;
                endcase
            end
            if (accept) begin
                ctrlOp_r <= reqOp;
            end
            if (apbWr && paddr == REG_ADDR && state_r == S_IDLE) begin
                addr_r <= pwdata[19:0];
            end
            if (apbWr && paddr == REG_WDATA && state_r == S_IDLE) begin
                wdata_r <= pwdata[15:0];
            end
            if (apbWr && paddr == REG_CONFIG) begin
                config_r <= pwdata[2:0];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign flashCeN = ceN_r;
    assign flashWeN = weN_r;
    assign flashOeN = oeN_r;
    assign flashAddr = pinAddr_r;
    assign flashDqOut = pinData_r;
    assign flashDqOeN = dqOeN_r;
    assign flashByteN = !config_r[CF_BYTE];
    assign flashResetN = !config_r[CF_HWRST];
    assign flashVidEn = config_r[CF_VID];

    // helper: write pulses issued in the running operation
    logic [2:0] weFalls_r;
    always_ff @(posedge clk) begin
        if (srst || accept) begin
            weFalls_r <= 3'd0;
        end else if (state_r == S_SETUP && state_nxt == S_PULSE && !cur.rd) begin
            weFalls_r <= weFalls_r + 3'd1;
        end
    end

    AST_WRITE_COMBO: assert property (@(posedge clk) disable iff (srst) !flashWeN |-> !flashCeN && flashOeN) // see R23
        else $error("write strobe without chip select or with output enable");
    AST_OE_WE_EXCL: assert property (@(posedge clk) disable iff (srst) !flashOeN |-> flashWeN && flashDqOeN) // see R23
        else $error("read strobe while writing or driving data");
    AST_PROG_FOUR: assert property (@(posedge clk) disable iff (srst)
        (state_r == S_HOLD && cnt_r == 8'd0 && op_r == OP_PROGRAM && isLast) |-> weFalls_r == 3'd4) // see R15
        else $error("program sequence not four writes");
    AST_BYP_TWO: assert property (@(posedge clk) disable iff (srst)
        (state_r == S_HOLD && cnt_r == 8'd0 && op_r == OP_BYPPROG && isLast) |-> weFalls_r == 3'd2) // see R21
        else $error("bypass program not two writes");
    AST_UNLOCK_MATCH: assert property (@(posedge clk) disable iff (srst)
        ($fell(flashWeN) && op_r == OP_PROGRAM && step_r == 2'd1) |-> flashAddr == UNLOCK_ADDR2 &&
        flashDqOut == UNLOCK_DATA2 && !flashDqOeN) // see R24
        else $error("second unlock write mismatched");
    AST_EXIT_DATA: assert property (@(posedge clk) disable iff (srst)
        ($fell(flashWeN) && op_r == OP_BYPEXIT) |-> flashDqOut == ((step_r == 2'd0) ? CMD_BYPEXIT1 : CMD_BYPEXIT2)) // see R22
        else $error("bypass exit data wrong");
    AST_HWRESET_STOP: assert property (@(posedge clk) disable iff (srst)
        (hwReset && state_r != S_IDLE) |=> state_r == S_IDLE && !flashResetN ##1 flashCeN && aborted_r) // see R18
        else $error("hardware reset did not end operation");
    AST_AUTOSEL_HOLD: assert property (@(posedge clk) disable iff (srst)
        (autosel_r && !hwReset && !(finish && op_r == OP_RESET)) |=> autosel_r) // see R10
        else $error("autoselect left without reset command");
endmodule : flash_host
`default_nettype wire

// >>> flash_dev_model.sv
`default_nettype none
module flash_dev_model #(
    parameter logic [19:0] UNLOCK_A1 = 20'h00555,
    parameter logic [19:0] UNLOCK_A2 = 20'h002aa,
    parameter logic [15:0] MAKER_CODE = 16'h00c3, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h1a2b, // arbitrary value
    parameter logic [15:0] CONT_CODE = 16'h0011, // arbitrary value
    parameter logic [3:0] LOCKED_SECTOR = 4'hf,
    parameter int BUSY_CLKS = 40
) (
    input wire logic clk,
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic [19:0] addr,
    input wire logic [15:0] dqIn,
    output logic [15:0] dqOut,
    input wire logic byteN,
    input wire logic resetN,
    input wire logic vidEn,
    output logic readyBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [2:0] {RD, U1, U2, PS, AS, BY, BP, BX} mode_t;
    mode_t st = RD;
    logic [15:0] mem [logic [19:0]];
    logic [19:0] aLat, pAddr;
    logic [15:0] pData;
    logic [15:0] lastDq = 16'h0;
    int busyCnt = 0;
    wire wrN = ceN | weN | ~oeN;
    wire rdEn = ~ceN & ~oeN;
    // array data, or identification data in autoselect mode
    function automatic logic [15:0] rdVal(input logic [19:0] a);
        if (st != AS) return mem.exists(a) ? mem[a] : 16'hffff;
        return a[7:0] == 8'h00 ? MAKER_CODE : a[7:0] == 8'h01 ? PART_CODE : a[7:0] == 8'h11 ? CONT_CODE :
            {15'h0, a[7:0] == 8'h02 && a[19:16] == LOCKED_SECTOR};
    endfunction
    // released bus shows the inverse of the last value, never a stale copy
    always @(posedge clk or rdEn) begin
        dqOut = rdEn ? rdVal(addr) : ~lastDq;
        if (rdEn) lastDq = dqOut;
    end
    // address on the later fall, data on the earlier rise
    always @(negedge wrN) aLat = addr;
    // a write edge decodes only with the reset pin high and no embedded program running
    always @(posedge wrN) if (resetN && busyCnt == 0) decode(aLat, dqIn);
    // command sequence decoder
    task automatic decode(input logic [19:0] a, input logic [15:0] d);
        if (d[7:0] == 8'hf0 && st < BY) st = RD;
        else case (st)
            RD: st = (a == UNLOCK_A1 && d[7:0] == 8'haa) ? U1 : RD;
            U1: st = (a == UNLOCK_A2 && d[7:0] == 8'h55) ? U2 : RD;
            U2: st = a != UNLOCK_A1 ? RD : d[7:0] == 8'ha0 ? PS : d[7:0] == 8'h90 ? AS :
                d[7:0] == 8'h20 ? BY : RD;
            PS, BP: begin
                if (a[19:16] != LOCKED_SECTOR || vidEn) begin
                    pAddr = a;
                    pData = byteN ? d : {8'hff, d[7:0]};
                    busyCnt = BUSY_CLKS;
                end
                st = st == BP ? BY : RD;
            end
            BY: st = d[7:0] == 8'ha0 ? BP : d[7:0] == 8'h90 ? BX : BY;
            BX: st = d[7:0] == 8'h00 ? RD : BY;
            default: ;
        endcase
    endtask
    // embedded program timer, cut short by the reset pin
    always @(posedge clk) begin
        if (!resetN) st = RD;
        if (busyCnt == 1 && resetN) mem[pAddr] = (mem.exists(pAddr) ? mem[pAddr] : 16'hffff) & pData;
        busyCnt = (!resetN || busyCnt == 0) ? 0 : busyCnt - 1;
    end
    assign readyBusy = busyCnt == 0;
endmodule // flash_dev_model
`default_nettype wire

// >>> test_flash_host.sv
`default_nettype none
module test_flash_host import flash_host_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER = 16'h00c3; // arbitrary value
    localparam logic [15:0] PART = 16'h1a2b; // arbitrary value
    localparam logic [15:0] CONT = 16'h0011; // arbitrary value
    logic clk = 1'b0;
    logic srst, psel, penable, pwrite, pready, pslverr, lastErr, readyBusy;
    logic flashCeN, flashWeN, flashOeN, flashDqOeN, flashByteN, flashResetN, flashVidEn;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [19:0] flashAddr, aA, aB;
    logic [15:0] flashDqOut, flashDqIn, modelDq, dA, dB;
    logic [63:0] noteQ[$];
    logic [63:0] note;
    logic [19:0] selAddr [5] = '{20'h00000, 20'h30001, 20'h55511, 20'hf0002, 20'h10002};
    logic [15:0] selCode [5] = '{MAKER, PART, CONT, 16'h0001, 16'h0000};
    int fail_count = 0;
    int num_checks = 0;
    int seed = 47;
    always #12.5ns clk = ~clk;
    // the shared data bus as seen by the controller
    assign flashDqIn = flashDqOeN ? modelDq : flashDqOut;
    flash_host dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .flashCeN, .flashWeN, .flashOeN, .flashAddr, .flashDqOut, .flashDqOeN, .flashDqIn, .flashByteN,
        .flashResetN, .flashVidEn, .readyBusy);
    flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .CONT_CODE(CONT)) fm (.clk(clk), .ceN(flashCeN),
        .weN(flashWeN), .oeN(flashOeN), .addr(flashAddr), .dqIn(flashDqOut), .dqOut(modelDq),
        .byteN(flashByteN), .resetN(flashResetN), .vidEn(flashVidEn), .readyBusy(readyBusy));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    // each completed read, while a note is pending, is compared against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && noteQ.size() > 0) begin
            note = noteQ.pop_front();
            check("prdata", prdata & note[63:32], note[31:0]);
        end
    end
    // one apb transfer; a nonzero mask notes an expected read value
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, m, e);
        int n;
        n = 0;
        if (m != '0) noteQ.push_back({m, e});
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) fail_count++;
        r = prdata;
        lastErr = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    // load address and data, clear sticky flags, start an operation
    task automatic op(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d, input logic ok);
        int n;
        xfer(1'b1, REG_ADDR, {12'h0, a}, '0, '0);
        xfer(1'b1, REG_WDATA, {16'h0, d}, '0, '0);
        xfer(1'b1, REG_STATUS, 32'h46, '0, '0);
        xfer(1'b1, REG_CTRL, {29'h0, o}, '0, '0);
        r = 32'h0;
        for (n = 0; ok && n < 100 && r[ST_DONE] !== 1'b1; n++) xfer(1'b0, REG_STATUS, '0, '0, '0);
        if (ok && r[ST_DONE] !== 1'b1) fail_count++;
    endtask
    task automatic fread(input logic [19:0] a, input logic [31:0] e);
        op(OP_READ, a, 16'h0, 1'b1);
        xfer(1'b0, REG_RDATA, '0, 32'hffffffff, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        summarize();
    end
    // main sequence
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, REG_CONFIG, '0, 32'h7, {29'h0, CONFIG_RESET});
        xfer(1'b0, 8'h18, '0, '0, '0);
        check("pslverr", {31'h0, lastErr}, 32'h1);
        aA = {4'h1, 16'($random(seed))};
        aB = aA ^ 20'h00100;
        dA = 16'($random(seed));
        dB = 16'($random(seed));
        fread(aA, 32'hffff);
        op(OP_PROGRAM, aA, dA, 1'b1);
        fread(aA, {16'h0, dA});
        op(OP_PROGRAM, aA, dB, 1'b1);
        fread(aA, {16'h0, dA & dB});
        $display("test program done");
        xfer(1'b1, REG_CONFIG, 32'h1, '0, '0);
        op(OP_PROGRAM, aB, dB, 1'b1);
        fread(aB, {24'h0, dB[7:0]});
        xfer(1'b1, REG_CONFIG, 32'h4, '0, '0);
        fread(aB, {16'h0, 8'hff, dB[7:0]});
        op(OP_PROGRAM, 20'hf0040, dA, 1'b1);
        xfer(1'b1, REG_CONFIG, 32'h0, '0, '0);
        fread(20'hf0040, {16'h0, dA});
        op(OP_PROGRAM, 20'hf0044, dA, 1'b1);
        fread(20'hf0044, 32'hffff);
        $display("test byte mode and protection done");
        op(OP_AUTOSEL, 20'h0, 16'h0, 1'b1);
        xfer(1'b0, REG_STATUS, '0, 32'h18, 32'h08);
        for (int i = 0; i < 5; i++) fread(selAddr[i], {16'h0, selCode[i]});
        op(OP_PROGRAM, aA, dA, 1'b0);
        xfer(1'b0, REG_STATUS, '0, 32'h1c, 32'h0c);
        op(OP_RESET, aA, 16'h0, 1'b1);
        fread(aA, {16'h0, dA & dB});
        $display("test autoselect done");
        op(OP_BYPASS, aA, 16'h0, 1'b1);
        xfer(1'b0, REG_STATUS, '0, 32'h18, 32'h10);
        op(OP_BYPPROG, aB + 20'h2, dA, 1'b1);
        op(OP_BYPPROG, aB + 20'h4, dB, 1'b1);
        op(OP_RESET, aA, 16'h0, 1'b0);
        xfer(1'b0, REG_STATUS, '0, 32'h14, 32'h14);
        op(OP_BYPEXIT, aA, 16'h0, 1'b1);
        xfer(1'b0, REG_STATUS, '0, 32'h10, 32'h0);
        fread(aB + 20'h2, {16'h0, dA});
        fread(aB + 20'h4, {16'h0, dB});
        $display("test bypass done");
        op(OP_PROGRAM, aA ^ 20'h00200, dB, 1'b0);
        xfer(1'b1, REG_CTRL, {29'h0, OP_READ}, '0, '0);
        xfer(1'b0, REG_STATUS, '0, 32'h5, 32'h5);
        xfer(1'b1, REG_CONFIG, 32'h2, '0, '0);
        xfer(1'b0, REG_STATUS, '0, 32'h41, 32'h40);
        check("resetPin", {31'h0, flashResetN}, 32'h0);
        xfer(1'b1, REG_CONFIG, 32'h0, '0, '0);
        fread(aA ^ 20'h00200, 32'hffff);
        op(OP_PROGRAM, aA ^ 20'h00200, dB, 1'b1);
        fread(aA ^ 20'h00200, {16'h0, dB});
        $display("test hardware reset done");
        summarize();
    end
endmodule // test_flash_host
`default_nettype wire
